// File: src/qeo_top.sv
// Purpose: quadrature A/B/index output and field diagnostics of the encoder
// Assumes: angle and field samples come from logic on clk
// Notes: output enable pin is asynchronous and is synchronised here

module qeo_top
    import qeo_pkg::*;
#(
    parameter int COMP_CYCLES = COMP_CYCLES_DEF,
    parameter int STEP_GAP = STEP_GAP_DEF,
    parameter logic [FIELD_W-1:0] FIELD_MIN = FIELD_MIN_DEF,
    parameter logic [FIELD_W-1:0] FIELD_MAX = FIELD_MAX_DEF,
    parameter logic [FIELD_W-1:0] FIELD_BAND = FIELD_BAND_DEF
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [FINE_W-1:0] angle_fine,
    input wire logic angle_valid,
    input wire logic [ANGLE_W-1:0] zero_pos,
    input wire logic [FIELD_W-1:0] field_mag,
    input wire logic field_valid,
    input wire logic output_enable_n,
    output qeo_quad_type quad,
    input wire logic field_rise_flag_in,
    output logic field_rise_flag_out,
    output logic field_rise_flag_oe,
    input wire logic field_fall_flag_in,
    output logic field_fall_flag_out,
    output logic field_fall_flag_oe
);

    localparam int CNT_W = $clog2(COMP_CYCLES + 1);

    // ---- output enable pin synchroniser
    // two flops: the pin is asynchronous to clk and may change at any time
    // only the second flop is read, the first may still be settling
    logic oe_n_meta_reg, oe_n_meta_next;
    logic oe_n_sync_reg, oe_n_sync_next;

    always_comb begin
        oe_n_meta_next = output_enable_n;
        oe_n_sync_next = oe_n_meta_reg;
    end

    // pin has a pull-up, so idle value is high
    always_ff @(posedge clk) begin
        if (!nrst) begin
            oe_n_meta_reg <= 1'b1;
            oe_n_sync_reg <= 1'b1;
        end else begin
            oe_n_meta_reg <= oe_n_meta_next;
            oe_n_sync_reg <= oe_n_sync_next;
        end
    end

    // ---- offset compensation wait after power-up
    // counts from reset release, so any later reset restarts the wait
    // the counter parks at the end, so done never drops until reset
    logic [CNT_W-1:0] comp_cnt_reg, comp_cnt_next;
    logic comp_done_reg, comp_done_next;

    always_comb begin
        comp_cnt_next = comp_cnt_reg;
        comp_done_next = comp_done_reg;
        if (!comp_done_reg) begin
            if (comp_cnt_reg == CNT_W'(COMP_CYCLES - 1)) begin
                comp_done_next = 1'b1;
            end else begin
                comp_cnt_next = comp_cnt_reg + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            comp_cnt_reg <= '0;
            comp_done_reg <= 1'b0;
        end else begin
            comp_cnt_reg <= comp_cnt_next;
            comp_done_reg <= comp_done_next;
        end
    end

    // ---- angle path: zero offset, hysteresis, stepping
    logic [FINE_W-1:0] angle_rel;
    logic [ANGLE_W-1:0] filt_pos;
    logic filt_valid;
    logic [ANGLE_W-1:0] step_pos;
    logic step_load;

    // zero code moves the index to the programmed position
    assign angle_rel = angle_fine - {zero_pos, 1'b0};

    // the filter works in half steps, so its reversal band is half a step
    // its direction flag is not needed outside it
    qeo_hyst_filter u_filter (
        .clk(clk),
        .nrst(nrst),
        .sample_valid(angle_valid),
        .fine_angle(angle_rel),
        .pos(filt_pos),
        .pos_valid(filt_valid),
        .dir_down()
    );

    // walking keeps one output edge per step even when the angle jumps
    qeo_stepper #(
        .STEP_GAP(STEP_GAP)
    ) u_stepper (
        .clk(clk),
        .nrst(nrst),
        .load(step_load),
        .target(filt_pos),
        .pos(step_pos)
    );

    // ---- output state
    qeo_state_type state_reg, state_next;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_FORCED_HIGH: begin
                // only the controller pulling the pin low leaves this state
                if (!oe_n_sync_reg) begin
                    state_next = ST_WAIT_COMP;
                end
            end
            ST_WAIT_COMP: begin
                // enabled, but outputs stay low until the offsets have settled
                if (comp_done_reg && filt_valid) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                // pin is no longer looked at once running
                state_next = ST_RUN;
            end
            default: begin
                // unused state code: fall back to the safe power-up state
                state_next = ST_FORCED_HIGH;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            // any reset, power-up or brown-out, lands in the flagged state
            state_reg <= ST_FORCED_HIGH;
        end else begin
            state_reg <= state_next;
        end
    end

    // stepper follows the target silently until outputs go live
    assign step_load = (state_reg != ST_RUN);

    // ---- quadrature and index outputs
    // bit positions of the channels inside a phase code {a, b}
    localparam int PH_A = 1;
    localparam int PH_B = 0;

    qeo_quad_type quad_reg, quad_next;
    logic [1:0] phase_ab;
    logic at_index;

    always_comb begin
        // rising position gives A before B
        unique case (step_pos[1:0])
            2'h0: phase_ab = QUAD_PH0;
            2'h1: phase_ab = QUAD_PH1;
            2'h2: phase_ab = QUAD_PH2;
            2'h3: phase_ab = QUAD_PH3;
        endcase
        at_index = (step_pos == INDEX_POS);
    end

    always_comb begin
        quad_next = '{a: 1'b0, b: 1'b0, index: 1'b0};
        unique case (state_reg)
            ST_FORCED_HIGH: begin
                quad_next = '{a: 1'b1, b: 1'b1, index: 1'b1};
            end
            ST_WAIT_COMP: begin
                quad_next = '{a: 1'b0, b: 1'b0, index: 1'b0};
            end
            ST_RUN: begin
                if (at_index) begin
                    quad_next = '{a: 1'b0, b: 1'b0, index: 1'b1};
                end else begin
                    quad_next.a = phase_ab[PH_A];
                    quad_next.b = phase_ab[PH_B];
                    quad_next.index = 1'b0;
                end
            end
            default: begin
                // unused state code: show the power-loss pattern
                quad_next = '{a: 1'b1, b: 1'b1, index: 1'b1};
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            quad_reg <= '{a: 1'b1, b: 1'b1, index: 1'b1};
        end else begin
            quad_reg <= quad_next;
        end
    end

    // pins come straight from a register, so decode glitches never reach them
    assign quad = quad_reg;

    // ---- magnetic field monitor
    qeo_field_type field_reg, field_next;
    // field level at the last reported change
    logic [FIELD_W-1:0] ref_reg, ref_next;
    logic ref_seen_reg, ref_seen_next;
    logic out_of_range;
    logic [FIELD_W-1:0] rise_amt, fall_amt;
    logic rise_big, fall_big;

    always_comb begin
        out_of_range = (field_mag < FIELD_MIN) || (field_mag > FIELD_MAX);
        rise_amt = field_mag - ref_reg;
        fall_amt = ref_reg - field_mag;
        // the band keeps noise on a still magnet from toggling the flags
        rise_big = (field_mag > ref_reg) && (rise_amt > FIELD_BAND);
        fall_big = (field_mag < ref_reg) && (fall_amt > FIELD_BAND);
        field_next = field_reg;
        ref_next = ref_reg;
        ref_seen_next = ref_seen_reg;
        if (field_valid) begin
            if (out_of_range) begin
                // re-base here, so the return into range shows as a move
                field_next = '{rise: 1'b1, fall: 1'b1};
                ref_next = field_mag;
                ref_seen_next = 1'b1;
            end else if (!ref_seen_reg) begin
                field_next = '{rise: 1'b0, fall: 1'b0};
                ref_next = field_mag;
                ref_seen_next = 1'b1;
            end else if (rise_big) begin
                field_next = '{rise: 1'b1, fall: 1'b0};
                ref_next = field_mag;
            end else if (fall_big) begin
                field_next = '{rise: 1'b0, fall: 1'b1};
                ref_next = field_mag;
            end else begin
                // small changes count as steady, reference kept
                field_next = '{rise: 1'b0, fall: 1'b0};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            field_reg <= '{rise: 1'b0, fall: 1'b0};
            ref_reg <= '0;
            ref_seen_reg <= 1'b0;
        end else begin
            field_reg <= field_next;
            ref_reg <= ref_next;
            ref_seen_reg <= ref_seen_next;
        end
    end

    // ---- open drain pins: only ever pull low
    // the data side is tied low and only the enable moves, so a flag
    // never fights the pull-up or the other flag on a shared line
    localparam int FLAG_N = 2;
    logic [FLAG_N-1:0] flag_on;
    logic [FLAG_N-1:0] flag_out;
    logic [FLAG_N-1:0] flag_oe;

    assign flag_on = {field_reg.rise, field_reg.fall};

    for (genvar i = 0; i < FLAG_N; i++) begin : g_flag
        assign flag_out[i] = 1'b0;
        assign flag_oe[i] = flag_on[i];
    end

    assign field_rise_flag_out = flag_out[1];
    assign field_rise_flag_oe = flag_oe[1];
    assign field_fall_flag_out = flag_out[0];
    assign field_fall_flag_oe = flag_oe[0];

endmodule : qeo_top

// File: src/qeo_pkg.sv
// Purpose: shared constants and types of the quadrature encoder output block
// Assumes: 125 MHz clock, angle front end on the same clock
// Notes: thresholds of the field monitor are plain defaults

package qeo_pkg;

    localparam int ANGLE_W = 8;
    localparam int FINE_W = ANGLE_W + 1;
    localparam int FIELD_W = 8;

    localparam int CLK_PERIOD_NS = 8;
    localparam int NS_PER_MS = 1000000;
    localparam int COMP_TIME_MS = 50;
    localparam int COMP_CYCLES_DEF = COMP_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;

    localparam int STEP_GAP_DEF = 1;
    localparam int GAP_W = 8;

    localparam logic [ANGLE_W-1:0] INDEX_POS = 8'h00;
    localparam logic [FIELD_W-1:0] FIELD_MIN_DEF = 8'h20;
    localparam logic [FIELD_W-1:0] FIELD_MAX_DEF = 8'he0;
    localparam logic [FIELD_W-1:0] FIELD_BAND_DEF = 8'h04;

    // {a, b} per step of a four-step cycle, one channel changes per step
    localparam logic [1:0] QUAD_PH0 = 2'h0;
    localparam logic [1:0] QUAD_PH1 = 2'h2;
    localparam logic [1:0] QUAD_PH2 = 2'h3;
    localparam logic [1:0] QUAD_PH3 = 2'h1;

    typedef struct packed {
        logic a;
        logic b;
        logic index;
    } qeo_quad_type;

    typedef struct packed {
        logic rise;
        logic fall;
    } qeo_field_type;

    typedef enum logic [1:0] {
        ST_FORCED_HIGH,
        ST_WAIT_COMP,
        ST_RUN
    } qeo_state_type;

endpackage : qeo_pkg

// File: src/qeo_hyst_filter.sv
// Purpose: reversal hysteresis on the fine angle, half a step wide
// Assumes: fine angle counts half steps, moves less than half a turn per sample
// Notes: edges sit half a step later while turning down

module qeo_hyst_filter
    import qeo_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic sample_valid,
    input wire logic [FINE_W-1:0] fine_angle,
    output logic [ANGLE_W-1:0] pos,
    output logic pos_valid,
    output logic dir_down
);

    logic [ANGLE_W-1:0] pos_reg, pos_next;
    logic valid_reg, valid_next;
    logic down_reg, down_next;
    logic [FINE_W:0] fine_plus;
    logic [ANGLE_W-1:0] cand_up, cand_dn, d_up, d_dn;
    logic up_ahead, dn_behind;

    always_comb begin
        fine_plus = {1'b0, fine_angle} + (FINE_W + 1)'(1);
        cand_up = fine_angle[FINE_W-1:1];
        cand_dn = fine_plus[ANGLE_W:1];
        d_up = cand_up - pos_reg;
        d_dn = cand_dn - pos_reg;
        up_ahead = (d_up != '0) && !d_up[ANGLE_W-1];
        dn_behind = d_dn[ANGLE_W-1];
        pos_next = pos_reg;
        valid_next = valid_reg;
        down_next = down_reg;
        if (sample_valid) begin
            if (!valid_reg) begin
                pos_next = cand_up;
                valid_next = 1'b1;
                down_next = 1'b0;
            end else if (!down_reg) begin
                if (up_ahead) begin
                    pos_next = cand_up;
                end else if (dn_behind) begin
                    pos_next = cand_dn;
                    down_next = 1'b1;
                end
            end else begin
                if (dn_behind) begin
                    pos_next = cand_dn;
                end else if (up_ahead) begin
                    pos_next = cand_up;
                    down_next = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pos_reg <= '0;
            valid_reg <= 1'b0;
            down_reg <= 1'b0;
        end else begin
            pos_reg <= pos_next;
            valid_reg <= valid_next;
            down_reg <= down_next;
        end
    end

    assign pos = pos_reg;
    assign pos_valid = valid_reg;
    assign dir_down = down_reg;

endmodule : qeo_hyst_filter

// File: src/qeo_stepper.sv
// Purpose: walks the output position one step at a time toward the target
// Assumes: target moves less than half a turn between steps
// Notes: load jumps without walking, used while outputs are not live

module qeo_stepper
    import qeo_pkg::*;
#(
    parameter int STEP_GAP = STEP_GAP_DEF
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic load,
    input wire logic [ANGLE_W-1:0] target,
    output logic [ANGLE_W-1:0] pos
);

    logic [ANGLE_W-1:0] pos_reg, pos_next, diff;
    logic [GAP_W-1:0] gap_reg, gap_next;

    always_comb begin
        diff = target - pos_reg;
        pos_next = pos_reg;
        gap_next = (gap_reg == '0) ? '0 : gap_reg - GAP_W'(1);
        if (load) begin
            pos_next = target;
            gap_next = GAP_W'(STEP_GAP - 1);
        end else if ((gap_reg == '0) && (diff != '0)) begin
            // one step, hence one edge, per move
            if (diff[ANGLE_W-1]) begin
                pos_next = pos_reg - ANGLE_W'(1);
            end else begin
                pos_next = pos_reg + ANGLE_W'(1);
            end
            gap_next = GAP_W'(STEP_GAP - 1);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pos_reg <= '0;
            gap_reg <= '0;
        end else begin
            pos_reg <= pos_next;
            gap_reg <= gap_next;
        end
    end

    assign pos = pos_reg;

endmodule : qeo_stepper

// File: testbench/qeo_top_props.sv
// Purpose: port checker of the quadrature output block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the top from the bench
module qeo_top_props
    import qeo_pkg::*;
#(
    parameter logic [FIELD_W-1:0] FIELD_MIN = FIELD_MIN_DEF,
    parameter logic [FIELD_W-1:0] FIELD_MAX = FIELD_MAX_DEF
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [FIELD_W-1:0] field_mag,
    input wire logic field_valid,
    input wire logic output_enable_n,
    input wire qeo_quad_type quad,
    input wire logic field_rise_flag_out,
    input wire logic field_rise_flag_oe,
    input wire logic field_fall_flag_out,
    input wire logic field_fall_flag_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic live_reg;
    logic live_next;
    logic out_range;
    assign out_range = field_mag < FIELD_MIN || field_mag > FIELD_MAX;
    // outputs have left forced-high since the last reset
    always_comb begin
        live_next = nrst && (live_reg || quad != 3'h7);
    end
    always_ff @(posedge clk) begin
        live_reg <= live_next;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    forced_start_a: assert property ($rose(nrst) |-> quad == 3'h7)
        else $error("outputs not forced high after reset");
    forced_hold_a: assert property (
        (output_enable_n && quad == 3'h7) [*6] |=> quad == 3'h7)
        else $error("forced state left without enable");
    enable_clear_a: assert property (
        (!output_enable_n) [*7] |-> quad != 3'h7)
        else $error("enable low did not clear forced state");
    latch_live_a: assert property (live_reg |-> quad != 3'h7)
        else $error("forced state came back");
    idx_ab_low_a: assert property (quad.index |-> quad.a == quad.b)
        else $error("index high with one channel high");
    gray_step_a: assert property (
        $past(quad) != 3'h0 && $past(quad) != 3'h7
        |-> $countones(($past(quad) ^ quad) & 3'h6) <= 1)
        else $error("both channels changed together");
    range_both_a: assert property (
        field_valid && out_range |=> field_rise_flag_oe && field_fall_flag_oe)
        else $error("out of range field not flagged");
    in_range_a: assert property (
        field_valid && !out_range |=> !(field_rise_flag_oe && field_fall_flag_oe))
        else $error("in range field flagged invalid");
    flags_hold_a: assert property (
        !field_valid |=> $stable({field_rise_flag_oe, field_fall_flag_oe}))
        else $error("flags moved without a sample");
    drain_low_a: assert property (
        field_rise_flag_out == 1'b0 && field_fall_flag_out == 1'b0)
        else $error("flag pin driven high");
    cover property (quad.index && quad != 3'h7);
    cover property (field_rise_flag_oe && !field_fall_flag_oe);
    cover property (!field_rise_flag_oe && field_fall_flag_oe);
endmodule : qeo_top_props

// File: testbench/qeo_counter_model.sv
// Purpose: external quadrature counter with pull-ups on the flag lines
// Assumes: decodes on the block clock
// Notes: counts a two-channel jump as a bad step
module qeo_counter_model
    import qeo_pkg::*;
(
    input wire logic clk,
    input wire logic enable_req,
    output logic output_enable_n,
    input wire qeo_quad_type quad,
    input wire logic rise_out,
    input wire logic rise_oe,
    input wire logic fall_out,
    input wire logic fall_oe,
    output logic rise_pin,
    output logic fall_pin,
    output logic shared_pin,
    output int position,
    output int index_hits,
    output int bad_steps
);
    timeunit 1ns;
    timeprecision 1ps;
    logic live;
    logic req_q;
    qeo_quad_type last_q;
    function automatic logic [1:0] phase_of(input logic [1:0] ab);
        case (ab)
            2'h0: return 2'h0;
            2'h2: return 2'h1;
            2'h3: return 2'h2;
            default: return 2'h3;
        endcase
    endfunction : phase_of
    assign rise_pin = rise_oe ? rise_out : 1'b1;
    assign fall_pin = fall_oe ? fall_out : 1'b1;
    assign shared_pin = rise_pin & fall_pin;
    initial begin
        output_enable_n = 1'b1;
        req_q = 1'b0;
        live = 1'b0;
        position = 0;
        index_hits = 0;
        bad_steps = 0;
    end
    // request taken on the rising edge, pin moved on the falling one
    always @(posedge clk) begin
        req_q <= enable_req;
    end
    always @(negedge clk) begin
        output_enable_n <= !req_q;
    end
    // a leading b counts up, b leading a counts down
    always @(posedge clk) begin
        last_q <= quad;
        live <= quad != 3'h7;
        if (live && quad != 3'h7) begin
            case (2'(phase_of({quad.a, quad.b}) - phase_of({last_q.a, last_q.b})))
                2'h1: position <= position + 1;
                2'h3: position <= position - 1;
                2'h2: bad_steps <= bad_steps + 1;
                default: ;
            endcase
            if (quad.index && !last_q.index) begin
                index_hits <= index_hits + 1;
            end
        end
    end
endmodule : qeo_counter_model

// File: testbench/qeo_top_tb_top.sv
// Purpose: self-checking bench of the quadrature output block
// Assumes: short compensation count, one step per cycle
// Notes: angle offsets are relative to the zero code
module qeo_top_tb_top
    import qeo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int COMP = 20;
    localparam logic [ANGLE_W-1:0] ZERO = 8'h10;
    logic clk, nrst, angle_valid, field_valid, enable_req, output_enable_n;
    logic [FINE_W-1:0] angle_fine;
    logic [ANGLE_W-1:0] zero_pos;
    logic [FIELD_W-1:0] field_mag;
    logic rise_out, rise_oe, fall_out, fall_oe, rise_pin, fall_pin, shared_pin;
    qeo_quad_type quad;
    int position, index_hits, bad_steps, miscompares, samples_checked, cycles;
    qeo_top #(.COMP_CYCLES(COMP), .STEP_GAP(1)) dut_u (
        .clk(clk), .nrst(nrst), .angle_fine(angle_fine), .angle_valid(angle_valid),
        .zero_pos(zero_pos), .field_mag(field_mag), .field_valid(field_valid),
        .output_enable_n(output_enable_n), .quad(quad), .field_rise_flag_in(rise_pin),
        .field_rise_flag_out(rise_out), .field_rise_flag_oe(rise_oe),
        .field_fall_flag_in(fall_pin), .field_fall_flag_out(fall_out),
        .field_fall_flag_oe(fall_oe));
    qeo_counter_model model_u (
        .clk(clk), .enable_req(enable_req), .output_enable_n(output_enable_n),
        .quad(quad), .rise_out(rise_out), .rise_oe(rise_oe), .fall_out(fall_out),
        .fall_oe(fall_oe), .rise_pin(rise_pin), .fall_pin(fall_pin),
        .shared_pin(shared_pin), .position(position), .index_hits(index_hits),
        .bad_steps(bad_steps));
    always #4 clk = ~clk;
    task automatic wrap_up;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic check_quad(input qeo_quad_type got, input qeo_quad_type exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t quad %b expected %b", $time, got, exp);
        end
    endtask : check_quad
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t value %0h expected %0h", $time, got, exp);
        end
    endtask : check_val
    function automatic qeo_quad_type exp_quad(input int p);
        logic [1:0] ab [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
        if (p % 256 == 0) begin
            return 3'h1;
        end
        return {ab[p % 4], 1'b0};
    endfunction : exp_quad
    task automatic step(input int rel, input int p);
        angle_fine = 9'(rel) + {ZERO, 1'b0};
        repeat (5) @(negedge clk);
        check_quad(quad, exp_quad(p));
    endtask : step
    task automatic t_power_flag;
        repeat (40) @(negedge clk);
        check_quad(quad, 3'h7);
        enable_req = 1'b1;
        @(negedge clk);
        enable_req = 1'b0;
        repeat (12) @(negedge clk);
        check_quad(quad, exp_quad(0));
    endtask : t_power_flag
    task automatic t_turn_cw;
        int pos0 = position;
        int hit0 = index_hits;
        int bad0 = bad_steps;
        for (int p = 1; p <= 256; p++) begin
            step((2 * p) % 512, p);
        end
        check_val(position - pos0, 256);
        check_val(index_hits - hit0, 1);
        check_val(bad_steps - bad0, 0);
    endtask : t_turn_cw
    task automatic t_reverse;
        int pos0;
        step(511, 0);
        step(510, 255);
        step(509, 255);
        pos0 = position;
        for (int k = 1; k <= 256; k++) begin
            step((510 - 2 * k) & 511, (511 - k) % 256);
        end
        check_val(position - pos0, -256);
        step(511, 255);
        step(0, 0);
        step(1, 0);
    endtask : t_reverse
    task automatic t_field;
        logic [9:0] tbl [9] = '{{8'h10, 2'h3}, {8'h80, 2'h2}, {8'h85, 2'h2},
            {8'h86, 2'h0}, {8'h80, 2'h1}, {8'hf0, 2'h3}, {8'h7c, 2'h1},
            {8'h20, 2'h1}, {8'h1f, 2'h3}};
        for (int i = 0; i < 9; i++) begin
            field_mag = tbl[i][9:2];
            field_valid = 1'b1;
            @(negedge clk);
            field_valid = 1'b0;
            repeat (2) @(negedge clk);
            check_val({rise_pin, fall_pin, shared_pin},
                {~tbl[i][1], ~tbl[i][0], ~|tbl[i][1:0]});
        end
    endtask : t_field
    task automatic t_enable_low;
        enable_req = 1'b1;
        nrst = 1'b0;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        repeat (10) @(negedge clk);
        check_quad(quad, 3'h0);
        repeat (COMP + 10) @(negedge clk);
        check_quad(quad, exp_quad(0));
    endtask : t_enable_low
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        angle_fine = {ZERO, 1'b0};
        angle_valid = 1'b1;
        zero_pos = ZERO;
        field_mag = 8'h80;
        field_valid = 1'b0;
        enable_req = 1'b0;
        miscompares = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        t_power_flag();
        t_turn_cw();
        t_reverse();
        t_field();
        t_enable_low();
        wrap_up();
    end
endmodule : qeo_top_tb_top
bind qeo_top qeo_top_props #(.FIELD_MIN(FIELD_MIN), .FIELD_MAX(FIELD_MAX)) props_u (
    .clk(clk), .nrst(nrst), .field_mag(field_mag), .field_valid(field_valid),
    .output_enable_n(output_enable_n), .quad(quad),
    .field_rise_flag_out(field_rise_flag_out), .field_rise_flag_oe(field_rise_flag_oe),
    .field_fall_flag_out(field_fall_flag_out), .field_fall_flag_oe(field_fall_flag_oe));
